// ### hw/msr_output_bank.sv
/*
 Read-only sensor output register bank: sample words, thermal byte, fusion
 flag registers, sample count and new-data status, read byte-wise by the
 host interface logic. Assumes the sample producer and the host port logic
 sit on the same clock and present single-cycle strobes.
*/
`timescale 1ns/100ps
// Functional notes
// - Acceleration X, Y, Z as signed 16-bit words at 0x19 to 0x1E.
// - Each word: bits 7:0 in the low byte, bits 15:8 in the high byte.
// - Angular rate X, Y, Z as signed 16-bit words at 0x1F to 0x24.
// - Magnetic field X, Y, Z as signed 16-bit words at 0x25 to 0x2A.
// - Orientation increment W, X, Y, Z as signed words at 0x2D to 0x34.
// - Velocity increment X, Y, Z as signed 16-bit words at 0x35 to 0x3A.
// - Temperature as one signed byte at 0x3B.
// - First flag register bit 7: field bias updated this output period.
// - First flag register bit 6: rate bias updated this output period.
// - First flag register bits 5, 4, 3: rate Z, Y, X clipped.
// - First flag register bits 2, 1, 0: acceleration Z, Y, X clipped.
// - Second flag register bits 5, 4, 3: field Z, Y, X clipped.
// - Second flag register bits 2, 1, 0: velocity increment Z, Y, X overflow.
// - Eight-bit sample count advances once per sample of fastest sensor.
// - New-data flag reads 0 without update since last status read, else 1.
module msr_output_bank
   import msr_pkg::*;
#(
   parameter int WORD_W = MSR_WORD_W,
   parameter int WORD_N = MSR_WORD_N
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic rd_en,
   input wire logic [MSR_ADDR_W-1:0] rd_addr,
   output logic [MSR_DATA_W-1:0] rd_data,
   output logic rd_valid,
   input wire logic smp_we,
   input wire logic [MSR_IDX_W-1:0] smp_idx,
   input wire logic [WORD_W-1:0] smp_word,
   input wire logic thermal_we,
   input wire logic [MSR_DATA_W-1:0] thermal_value,
   input wire logic accel_done,
   input wire logic rate_done,
   input wire logic field_done,
   input wire logic sample_tick,
   input wire logic fusion_we,
   input wire logic field_bias_updated,
   input wire logic rate_bias_updated,
   input wire logic rate_z_clipped,
   input wire logic rate_y_clipped,
   input wire logic rate_x_clipped,
   input wire logic accel_z_clipped,
   input wire logic accel_y_clipped,
   input wire logic accel_x_clipped,
   input wire logic field_z_clipped,
   input wire logic field_y_clipped,
   input wire logic field_x_clipped,
   input wire logic vel_z_overflow,
   input wire logic vel_y_overflow,
   input wire logic vel_x_overflow
);

   // Address decode: which byte of which word, or which single register
   function automatic msr_sel_t decode_sel(input logic [7:0] addr);
      logic [7:0] rel;
      rel = 8'h00;
      if (addr >= MSR_OFS_ACCEL_X_LOW && addr <= MSR_OFS_FIELD_Z_HIGH) begin
         rel = addr - MSR_OFS_ACCEL_X_LOW;
         decode_sel = rel[0] ? MSR_SEL_WORD_HIGH : MSR_SEL_WORD_LOW;
      end else if (addr >= MSR_OFS_ORIENT_W_LOW && addr <= MSR_OFS_VEL_Z_HIGH) begin
         rel = addr - MSR_OFS_ORIENT_W_LOW;
         decode_sel = rel[0] ? MSR_SEL_WORD_HIGH : MSR_SEL_WORD_LOW;
      end else if (addr == MSR_OFS_THERMAL) begin
         decode_sel = MSR_SEL_THERMAL;
      end else if (addr == MSR_OFS_FLAGS_FIRST) begin
         decode_sel = MSR_SEL_FLAGS_FIRST;
      end else if (addr == MSR_OFS_FLAGS_SECOND) begin
         decode_sel = MSR_SEL_FLAGS_SECOND;
      end else if (addr == MSR_OFS_COUNT) begin
         decode_sel = MSR_SEL_COUNT;
      end else if (addr == MSR_OFS_STATUS) begin
         decode_sel = MSR_SEL_STATUS;
      end else begin
         decode_sel = MSR_SEL_NONE;
      end
   endfunction

   // Word slot of a byte address; the gap at 0x2B-0x2C is skipped
   function automatic logic [3:0] decode_idx(input logic [7:0] addr);
      logic [7:0] rel;
      rel = 8'h00;
      if (addr >= MSR_OFS_ORIENT_W_LOW) begin
         rel = (addr - MSR_OFS_ORIENT_W_LOW) >> 1;
         decode_idx = MSR_W_ORIENT_W + rel[3:0];
      end else begin
         rel = (addr - MSR_OFS_ACCEL_X_LOW) >> 1;
         decode_idx = rel[3:0];
      end
   endfunction

   msr_sel_t rd_sel;
   logic [MSR_IDX_W-1:0] rd_idx;
   logic status_read;

   msr_sel_t sel_reg;
   logic [MSR_IDX_W-1:0] idx_reg;
   logic pend_reg;

   logic [WORD_W-1:0] mem_word;

   logic [7:0] thermal_reg;
   logic [7:0] flags_first_reg;
   logic [7:0] flags_first_next;
   logic [5:0] flags_second_reg;
   logic [5:0] flags_second_next;
   logic [7:0] sample_count_reg;
   logic [3:0] new_data_reg;
   logic [3:0] new_data_set;
   logic [3:0] new_data_next;
   logic [3:0] status_snap_reg;

   logic [7:0] shadow_reg;
   logic [MSR_IDX_W-1:0] shadow_idx_reg;
   logic shadow_ok_reg;
   logic shadow_hit;
   logic [7:0] high_byte;

   logic [MSR_DATA_W-1:0] rd_data_reg;
   logic [MSR_DATA_W-1:0] rd_data_next;
   logic rd_valid_reg;

   assign rd_sel = decode_sel(rd_addr);
   assign rd_idx = decode_idx(rd_addr);
   assign status_read = rd_en && (rd_sel == MSR_SEL_STATUS);

   // Whole words land in one write, so no half-updated pair is ever visible
   msr_word_mem #(
      .WIDTH(WORD_W),
      .DEPTH(WORD_N),
      .IDX_W(MSR_IDX_W)
   ) u_words (
      .clk(clk),
      .rst_b(rst_b),
      .wr_en(smp_we),
      .wr_idx(smp_idx),
      .wr_word(smp_word),
      .rd_idx(rd_idx),
      .rd_word(mem_word)
   );

   // Read request pipeline, first stage
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pend_reg <= 1'b0;
         sel_reg <= MSR_SEL_NONE;
         idx_reg <= MSR_IDX_RESET;
      end else begin
         pend_reg <= rd_en;
         sel_reg <= rd_sel;
         idx_reg <= rd_idx;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         thermal_reg <= MSR_BYTE_RESET;
      end else if (thermal_we) begin
         thermal_reg <= thermal_value;
      end
   end

   // Flags describe one output period, so each period replaces the last
   assign flags_first_next = {field_bias_updated,
                              rate_bias_updated,
                              rate_z_clipped, rate_y_clipped, rate_x_clipped,
                              accel_z_clipped, accel_y_clipped, accel_x_clipped};
   assign flags_second_next = {field_z_clipped, field_y_clipped, field_x_clipped,
                               vel_z_overflow, vel_y_overflow, vel_x_overflow};

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         flags_first_reg <= MSR_BYTE_RESET;
         flags_second_reg <= MSR_BYTE_RESET[5:0];
      end else if (fusion_we) begin
         flags_first_reg <= flags_first_next;
         flags_second_reg <= flags_second_next;
      end
   end

   // Wraps modulo 256; the first sample after reset reads as 1
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sample_count_reg <= MSR_BYTE_RESET;
      end else if (sample_tick) begin
         sample_count_reg <= sample_count_reg + 8'h01;
      end
   end

   // A new sample arriving in the read cycle survives the clear
   always_comb begin
      new_data_set = 4'h0;
      new_data_set[MSR_ST_FUSION] = fusion_we;
      new_data_set[MSR_ST_FIELD] = field_done;
      new_data_set[MSR_ST_RATE] = rate_done;
      new_data_set[MSR_ST_ACCEL] = accel_done;
   end

   assign new_data_next = (status_read ? 4'h0 : new_data_reg) | new_data_set;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         new_data_reg <= 4'h0;
         status_snap_reg <= 4'h0;
      end else begin
         new_data_reg <= new_data_next;
         if (status_read) begin
            status_snap_reg <= new_data_reg;
         end
      end
   end

   // High byte held at the low-byte read, so a later sample cannot split a pair
   assign shadow_hit = shadow_ok_reg && (shadow_idx_reg == idx_reg);
   assign high_byte = shadow_hit ? shadow_reg : mem_word[15:8];

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         shadow_reg <= MSR_BYTE_RESET;
         shadow_idx_reg <= MSR_IDX_RESET;
         shadow_ok_reg <= 1'b0;
      end else if (pend_reg && sel_reg == MSR_SEL_WORD_LOW) begin
         shadow_reg <= mem_word[15:8];
         shadow_idx_reg <= idx_reg;
         shadow_ok_reg <= 1'b1;
      end else if (pend_reg && sel_reg == MSR_SEL_WORD_HIGH) begin
         shadow_ok_reg <= 1'b0;
      end
   end

   // Byte selection; there is no write path, so host writes change nothing
   always_comb begin
      case (sel_reg)
         MSR_SEL_WORD_LOW: rd_data_next = mem_word[7:0];
         MSR_SEL_WORD_HIGH: rd_data_next = high_byte;
         MSR_SEL_THERMAL: rd_data_next = thermal_reg;
         MSR_SEL_FLAGS_FIRST: rd_data_next = flags_first_reg;
         MSR_SEL_FLAGS_SECOND: rd_data_next = {2'b00, flags_second_reg};
         MSR_SEL_COUNT: rd_data_next = sample_count_reg;
         MSR_SEL_STATUS: rd_data_next = {4'h0, status_snap_reg};
         default: rd_data_next = MSR_BYTE_RESET;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rd_data_reg <= MSR_BYTE_RESET;
         rd_valid_reg <= 1'b0;
      end else begin
         rd_valid_reg <= pend_reg;
         if (pend_reg) begin
            rd_data_reg <= rd_data_next;
         end
      end
   end

   assign rd_data = rd_data_reg;
   assign rd_valid = rd_valid_reg;

endmodule

// ### shared/msr_pkg.sv
/*
 Package for the motion sensor output register bank: byte offsets of the
 host-visible registers, word slots of the sample store, flag positions and
 reset values. Assumes a byte-wide host register port with 8-bit addresses.
*/
package msr_pkg;

   localparam int MSR_ADDR_W = 8;
   localparam int MSR_DATA_W = 8;
   localparam int MSR_WORD_W = 16;
   localparam int MSR_WORD_N = 16;
   localparam int MSR_IDX_W = 4;

   // Byte offsets on the host port
   localparam logic [7:0] MSR_OFS_STATUS = 8'h16;
   localparam logic [7:0] MSR_OFS_COUNT = 8'h18;
   localparam logic [7:0] MSR_OFS_ACCEL_X_LOW = 8'h19;
   localparam logic [7:0] MSR_OFS_ACCEL_Z_HIGH = 8'h1E;
   localparam logic [7:0] MSR_OFS_RATE_X_LOW = 8'h1F;
   localparam logic [7:0] MSR_OFS_RATE_Z_HIGH = 8'h24;
   localparam logic [7:0] MSR_OFS_FIELD_X_LOW = 8'h25;
   localparam logic [7:0] MSR_OFS_FIELD_Z_HIGH = 8'h2A;
   localparam logic [7:0] MSR_OFS_ORIENT_W_LOW = 8'h2D;
   localparam logic [7:0] MSR_OFS_ORIENT_Z_HIGH = 8'h34;
   localparam logic [7:0] MSR_OFS_VEL_X_LOW = 8'h35;
   localparam logic [7:0] MSR_OFS_VEL_Z_HIGH = 8'h3A;
   localparam logic [7:0] MSR_OFS_THERMAL = 8'h3B;
   localparam logic [7:0] MSR_OFS_FLAGS_FIRST = 8'h3C;
   localparam logic [7:0] MSR_OFS_FLAGS_SECOND = 8'h3D;

   // Word slots of the sample store, in host address order
   localparam logic [3:0] MSR_W_ACCEL_X = 4'h0;
   localparam logic [3:0] MSR_W_ACCEL_Y = 4'h1;
   localparam logic [3:0] MSR_W_ACCEL_Z = 4'h2;
   localparam logic [3:0] MSR_W_RATE_X = 4'h3;
   localparam logic [3:0] MSR_W_RATE_Y = 4'h4;
   localparam logic [3:0] MSR_W_RATE_Z = 4'h5;
   localparam logic [3:0] MSR_W_FIELD_X = 4'h6;
   localparam logic [3:0] MSR_W_FIELD_Y = 4'h7;
   localparam logic [3:0] MSR_W_FIELD_Z = 4'h8;
   localparam logic [3:0] MSR_W_ORIENT_W = 4'h9;
   localparam logic [3:0] MSR_W_ORIENT_X = 4'hA;
   localparam logic [3:0] MSR_W_ORIENT_Y = 4'hB;
   localparam logic [3:0] MSR_W_ORIENT_Z = 4'hC;
   localparam logic [3:0] MSR_W_VEL_X = 4'hD;
   localparam logic [3:0] MSR_W_VEL_Y = 4'hE;
   localparam logic [3:0] MSR_W_VEL_Z = 4'hF;

   // First fusion flag register
   localparam int MSR_F1_FIELD_BIAS = 7;
   localparam int MSR_F1_RATE_BIAS = 6;
   localparam int MSR_F1_RATE_Z = 5;
   localparam int MSR_F1_RATE_Y = 4;
   localparam int MSR_F1_RATE_X = 3;
   localparam int MSR_F1_ACCEL_Z = 2;
   localparam int MSR_F1_ACCEL_Y = 1;
   localparam int MSR_F1_ACCEL_X = 0;

   // Second fusion flag register, bits 7:6 reserved
   localparam int MSR_F2_FIELD_Z = 5;
   localparam int MSR_F2_FIELD_Y = 4;
   localparam int MSR_F2_FIELD_X = 3;
   localparam int MSR_F2_VEL_Z = 2;
   localparam int MSR_F2_VEL_Y = 1;
   localparam int MSR_F2_VEL_X = 0;

   // New-data flags in the status register
   localparam int MSR_ST_FUSION = 3;
   localparam int MSR_ST_FIELD = 2;
   localparam int MSR_ST_RATE = 1;
   localparam int MSR_ST_ACCEL = 0;

   localparam logic [7:0] MSR_BYTE_RESET = 8'h00;
   localparam logic [15:0] MSR_WORD_RESET = 16'h0000;
   localparam logic [3:0] MSR_IDX_RESET = 4'h0;

   typedef enum logic [2:0] {
      MSR_SEL_NONE,
      MSR_SEL_WORD_LOW,
      MSR_SEL_WORD_HIGH,
      MSR_SEL_THERMAL,
      MSR_SEL_FLAGS_FIRST,
      MSR_SEL_FLAGS_SECOND,
      MSR_SEL_COUNT,
      MSR_SEL_STATUS
   } msr_sel_t;

endpackage

// ### hw/msr_word_mem.sv
/*
 Small word store for the 16-bit sample values: one write port, one read
 port with registered read data. Assumes a single clock and a synchronous,
 active-low reset; slots not written since reset read as zero.
*/
`timescale 1ns/100ps
module msr_word_mem
   import msr_pkg::*;
#(
   parameter int WIDTH = MSR_WORD_W,
   parameter int DEPTH = MSR_WORD_N,
   parameter int IDX_W = MSR_IDX_W
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic wr_en,
   input wire logic [IDX_W-1:0] wr_idx,
   input wire logic [WIDTH-1:0] wr_word,
   input wire logic [IDX_W-1:0] rd_idx,
   output logic [WIDTH-1:0] rd_word
);

   logic [WIDTH-1:0] store [DEPTH];
   logic [DEPTH-1:0] filled_reg;
   logic [WIDTH-1:0] rd_word_reg;
   logic [WIDTH-1:0] rd_word_next;

   // Storage has no reset; the filled mask makes untouched slots read zero
   always_ff @(posedge clk) begin
      if (wr_en) begin
         store[wr_idx] <= wr_word;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         filled_reg <= '0;
      end else if (wr_en) begin
         filled_reg[wr_idx] <= 1'b1;
      end
   end

   assign rd_word_next = filled_reg[rd_idx] ? store[rd_idx] : MSR_WORD_RESET;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rd_word_reg <= MSR_WORD_RESET;
      end else begin
         rd_word_reg <= rd_word_next;
      end
   end

   assign rd_word = rd_word_reg;

endmodule

// ### bench/msr_host_model.sv
/*
 Host reader model for the output register bank: issues byte reads and
 notes the byte each read should return. Assumes one calling process.
*/
`timescale 1ns/100ps
module msr_host_model
   import msr_pkg::*;
(
   input wire logic clk,
   output logic rd_en,
   output logic [MSR_ADDR_W-1:0] rd_addr
);
   logic [7:0] exp_q[$];
   logic [7:0] adr_q[$];
   initial begin
      rd_en = 1'b0;
      rd_addr = 8'h00;
   end
   // Request changes at the falling edge and stands a full cycle
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      rd_en = 1'b1;
      rd_addr = a;
      exp_q.push_back(e);
      adr_q.push_back(a);
   endtask
   // Idle address flips so a stale value never passes for a request
   task automatic idle();
      @(negedge clk);
      rd_en = 1'b0;
      rd_addr = ~rd_addr;
   endtask
endmodule

// ### bench/msr_output_bank_sva.sv
/*
 Checker for the output register bank: read timing, thermal, count, status
 and reserved bits at the top ports. Assumes one clock, synchronous reset.
*/
`timescale 1ns/100ps
module msr_output_bank_sva
   import msr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic rd_en,
   input wire logic [MSR_ADDR_W-1:0] rd_addr,
   input wire logic [MSR_DATA_W-1:0] rd_data,
   input wire logic rd_valid,
   input wire logic thermal_we,
   input wire logic [MSR_DATA_W-1:0] thermal_value,
   input wire logic accel_done,
   input wire logic rate_done,
   input wire logic field_done,
   input wire logic sample_tick,
   input wire logic fusion_we
);
   logic [7:0] th_reg;
   logic [7:0] cnt_reg;
   logic st_rd;
   assign st_rd = rd_en && rd_addr == MSR_OFS_STATUS;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Shadows hold what a read taken at an edge must return
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         th_reg <= 8'h00;
         cnt_reg <= 8'h00;
      end else begin
         if (thermal_we) begin
            th_reg <= thermal_value;
         end
         if (sample_tick) begin
            cnt_reg <= cnt_reg + 8'h01;
         end
      end
   end
   sequence quiet_status_rd;
      st_rd && !accel_done && !rate_done && !field_done && !fusion_we;
   endsequence
   sequence accel_then_status;
      accel_done ##1 !st_rd ##1 st_rd;
   endsequence
   a_answer_two_later: assert property (rd_en |-> ##2 rd_valid)
      else $error("read answer missing two cycles after request");
   a_no_spurious_valid: assert property (rd_valid |-> $past(rd_en, 2))
      else $error("answer without a request");
   a_data_holds_idle: assert property (!rd_valid && $past(rst_b) |-> $stable(rd_data))
      else $error("read data moved without an answer");
   // The byte is picked one edge after the request, so a load at the request edge shows
   a_thermal_read: assert property (rd_en && rd_addr == MSR_OFS_THERMAL |-> ##2 rd_data == $past(th_reg))
      else $error("thermal byte wrong");
   a_count_read: assert property (rd_en && rd_addr == MSR_OFS_COUNT |-> ##2 rd_data == $past(cnt_reg))
      else $error("sample count wrong");
   a_status_clears: assert property (quiet_status_rd ##1 quiet_status_rd |-> ##2 rd_data[3:0] == 4'h0)
      else $error("status not cleared by read");
   a_status_sets: assert property (accel_then_status |-> ##2 rd_data[MSR_ST_ACCEL])
      else $error("accel new-data flag not set");
   a_unmapped_zero: assert property (rd_en && rd_addr inside {8'h2B, 8'h2C} |-> ##2 rd_data == 8'h00)
      else $error("hole address not zero");
   a_reserved_zero: assert property (rd_en && rd_addr == MSR_OFS_FLAGS_SECOND |-> ##2 rd_data[7:6] == 2'b00)
      else $error("reserved flag bits not zero");
endmodule
bind msr_output_bank msr_output_bank_sva u_sva (.clk(clk), .rst_b(rst_b), .rd_en(rd_en), .rd_addr(rd_addr),
   .rd_data(rd_data), .rd_valid(rd_valid), .thermal_we(thermal_we), .thermal_value(thermal_value),
   .accel_done(accel_done), .rate_done(rate_done), .field_done(field_done), .sample_tick(sample_tick),
   .fusion_we(fusion_we));

// ### bench/msr_output_bank_tb.sv
/*
 Self-checking bench for the output register bank: host reads through the
 host model, answers compared in order by a monitor. Assumes 50 MHz clock.
*/
`timescale 1ns/100ps
module msr_output_bank_tb;
   import msr_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic smp_we = 1'b0;
   logic thermal_we = 1'b0;
   logic accel_done = 1'b0;
   logic rate_done = 1'b0;
   logic field_done = 1'b0;
   logic sample_tick = 1'b0;
   logic fusion_we = 1'b0;
   logic [3:0] smp_idx = 4'h0;
   logic [15:0] smp_word = 16'h0000;
   logic [7:0] thermal_value = 8'h00;
   logic [13:0] fl = 14'h0000;
   logic rd_en;
   logic rd_valid;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   logic [7:0] e;
   logic [15:0] w[16];
   int n_fail = 0;
   int num_checks = 0;
   always #10 clk = ~clk;
   msr_host_model host (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr));
   msr_output_bank uut (.clk(clk), .rst_b(rst_b), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
      .rd_valid(rd_valid), .smp_we(smp_we), .smp_idx(smp_idx), .smp_word(smp_word), .thermal_we(thermal_we),
      .thermal_value(thermal_value), .accel_done(accel_done), .rate_done(rate_done), .field_done(field_done),
      .sample_tick(sample_tick), .fusion_we(fusion_we), .field_bias_updated(fl[7]),
      .rate_bias_updated(fl[6]), .rate_z_clipped(fl[5]), .rate_y_clipped(fl[4]), .rate_x_clipped(fl[3]),
      .accel_z_clipped(fl[2]), .accel_y_clipped(fl[1]), .accel_x_clipped(fl[0]), .field_z_clipped(fl[13]),
      .field_y_clipped(fl[12]), .field_x_clipped(fl[11]), .vel_z_overflow(fl[10]), .vel_y_overflow(fl[9]),
      .vel_x_overflow(fl[8]));
   function automatic logic [7:0] lo(input int i);
      return 8'(8'h19 + 2 * i + (i >= 9 ? 2 : 0));
   endfunction
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask
   task automatic put_word(input int i, input logic [15:0] v);
      @(negedge clk);
      smp_we = 1'b1;
      smp_idx = 4'(i);
      smp_word = v;
      w[i] = v;
      @(negedge clk);
      smp_we = 1'b0;
      smp_word = ~v;
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Answers come back in request order, so the oldest note matches
   always @(negedge clk) begin
      if (rd_valid === 1'b1) begin
         num_checks++;
         if (host.exp_q.size() == 0) begin
            n_fail++;
            $display("BAD rd_data expected none seen %h", rd_data);
         end else begin
            if (rd_data !== host.exp_q[0]) begin
               n_fail++;
               $display("BAD rd_data at %h expected %h seen %h", host.adr_q[0], host.exp_q[0], rd_data);
            end
            host.exp_q.delete(0);
            host.adr_q.delete(0);
         end
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      $display("BAD watchdog expected finish seen timeout");
      test_done();
   end
   initial begin
      void'($urandom(23));
      repeat (20) @(posedge clk);
      @(negedge clk);
      rst_b = 1'b1;
      for (int a = 8'h19; a <= 8'h3D; a++) host.rd(8'(a), 8'h00);
      // Drop the request before the strobes, or the last address is read again
      host.idle();
      pulse(field_done);
      pulse(rate_done);
      pulse(accel_done);
      host.rd(MSR_OFS_STATUS, 8'h07);
      host.rd(MSR_OFS_STATUS, 8'h00);
      host.idle();
      for (int i = 0; i < 16; i++) put_word(i, 16'($urandom));
      for (int i = 0; i < 16; i++) begin
         host.rd(lo(i), w[i][7:0]);
         host.rd(lo(i) + 8'h01, w[i][15:8]);
      end
      host.rd(lo(0), w[0][7:0]);
      host.idle();
      e = w[0][15:8];
      put_word(0, ~w[0]);
      host.rd(lo(0) + 8'h01, e);
      host.rd(lo(0) + 8'h01, w[0][15:8]);
      host.idle();
      thermal_value = 8'($urandom) | 8'h80;
      e = thermal_value;
      pulse(thermal_we);
      thermal_value = ~e;
      host.rd(MSR_OFS_THERMAL, e);
      host.idle();
      // Walking one over all fourteen flags, then all set
      for (int k = 0; k < 15; k++) begin
         fl = (k < 14) ? 14'h0001 << k : 14'h3FFF;
         pulse(fusion_we);
         e = {2'b00, fl[13:8]};
         host.rd(MSR_OFS_FLAGS_FIRST, fl[7:0]);
         fl = ~fl;
         host.rd(MSR_OFS_FLAGS_SECOND, e);
         host.idle();
      end
      host.rd(MSR_OFS_STATUS, 8'h08);
      host.idle();
      repeat (300) pulse(sample_tick);
      host.rd(MSR_OFS_COUNT, 8'h2C);
      host.idle();
      repeat (3) @(negedge clk);
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      host.rd(lo(5) + 8'h01, 8'h00);
      host.rd(MSR_OFS_COUNT, 8'h00);
      host.idle();
      repeat (4) @(negedge clk);
      if (host.exp_q.size() != 0) begin
         n_fail++;
         $display("BAD answers_left expected 0 seen %0d", host.exp_q.size());
      end
      test_done();
   end
endmodule
